// ==== design/sfr_pkg.sv ====
// Package for the sequencer and result FIFO control register bank.
// Assumes a single clock domain; offsets are byte addresses on the register bus.
package sfr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [15:0] OFF_SEQ_CONFIG    = 16'h2004;
   localparam logic [15:0] OFF_FIFO_CONFIG   = 16'h2008;
   localparam logic [15:0] OFF_CHECKSUM      = 16'h2060;
   localparam logic [15:0] OFF_TIMEOUT       = 16'h2068;
   localparam logic [15:0] OFF_RESULT_PORT   = 16'h206C;
   localparam logic [15:0] OFF_COMMAND_PORT  = 16'h2070;
   localparam logic [15:0] OFF_SLEEP_LOCK    = 16'h2118;
   localparam logic [15:0] OFF_SLEEP_TRIG    = 16'h211C;
   localparam logic [15:0] OFF_IRQ_STATUS    = 16'h2300;
   localparam logic [15:0] OFF_IRQ_MASK      = 16'h2304;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions, reset values, CRC polynomial and sleep password
   localparam int          SRC_LSB           = 13;
   localparam int          FIFO_EN_BIT       = 11;
   localparam int          HALT_BIT          = 1;
   localparam logic [15:0] FIFO_CONFIG_RESET = 16'h1010;
   localparam logic [1:0]  SEQ_CONFIG_RESET  = 2'h2;
   localparam logic [7:0]  CHECKSUM_RESET    = 8'h01;
   localparam logic [7:0]  CRC_POLY          = 8'h07;
   localparam logic [19:0] SLEEP_PASSWORD    = 20'hA47E5;

   ////////////////////////////////////////////////////////////////////////////
   // Result source codes
   localparam logic [2:0]  SRC_DFT           = 3'h2;
   localparam logic [2:0]  SRC_SINC2         = 3'h3;
   localparam logic [2:0]  SRC_VARIANCE      = 3'h4;
   localparam logic [2:0]  SRC_MEAN          = 3'h5;

   ////////////////////////////////////////////////////////////////////////////
   // Grouped signals
   typedef struct packed {
      logic [17:0] re;
      logic [17:0] im;
   } sfr_dft_t;

   typedef struct packed {
      logic slept;
      logic halted;
      logic res_drop;
      logic cmd_drop;
   } sfr_irq_t;

endpackage

// ==== design/sfr_regs.sv ====
// Register bank for the command sequencer and the result FIFO.
// Assumes an Avalon-MM master on the same clock and a sequencer core beside it.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module sfr_regs #(
   parameter int RES_DEPTH = 16,
   parameter int CMD_DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             resetn,
   // Avalon-MM slave
   input  wire logic [15:0]      avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   input  wire logic [3:0]       avs_byteenable,
   output logic      [31:0]      avs_readdata,
   output logic                  avs_waitrequest,
   // Processing results
   input  wire logic             sinc3_valid,
   input  wire logic [15:0]      sinc3_data,
   input  wire logic             dft_valid,
   input  wire sfr_pkg::sfr_dft_t dft_data,
   input  wire logic             sinc2_valid,
   input  wire logic [15:0]      sinc2_data,
   input  wire logic             variance_valid,
   input  wire logic [29:0]      variance_data,
   input  wire logic             mean_valid,
   input  wire logic [15:0]      mean_data,
   // Sequencer side
   input  wire logic             cmd_pop,
   output logic                  cmd_valid,
   output logic      [31:0]      cmd_data,
   output logic                  cmd_empty,
   output logic                  seq_halted,
   input  wire logic             cmd_executed,
   input  wire logic [31:0]      cmd_executed_word,
   input  wire logic [29:0]      seq_timeout_count,
   input  wire logic             seq_end,
   output logic                  sleep_enter,
   // Interrupt
   output logic                  irq
);

   localparam int RAW = $clog2(RES_DEPTH);
   localparam int CAW = $clog2(CMD_DEPTH);

   ////////////////////////////////////////////////////////////////////////////
   // CRC-8 over one 32-bit command, MSB first
   function automatic logic [7:0] crc8_word(input logic [7:0] crc_in, input logic [31:0] d);
      logic [7:0] c;
      logic       fb;
      c = crc_in;
      for (int i = 31; i >= 0; i--)
      begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? sfr_pkg::CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   // Byte-enable merge of a write into an old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (wd & m);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, then accept
   logic        done;
   logic        rd_had;
   logic [15:0] fifo_config;
   logic [1:0]  seq_config;
   logic [7:0]  checksum;
   logic [29:0] timeout_q;
   logic [19:0] sleep_lock;
   logic        sleep_trig;
   logic [3:0]  irq_status;
   logic [3:0]  irq_mask;
   logic [31:0] res_mem [RES_DEPTH];
   logic [31:0] cmd_mem [CMD_DEPTH];
   logic [RAW-1:0] res_wr;
   logic [RAW-1:0] res_rd;
   logic [RAW:0]   res_count;
   logic [CAW-1:0] cmd_wr;
   logic [CAW-1:0] cmd_rd;
   logic [CAW:0]   cmd_count;
   logic        pend;
   logic [31:0] pend_word;

   wire req     = avs_read | avs_write;
   wire acc_rd  = avs_read & done;
   wire acc_wr  = avs_write & done;
   wire first_rd = avs_read & ~done;
   assign avs_waitrequest = req & ~done;

   // Address decode
   wire sel_fcfg  = avs_address == sfr_pkg::OFF_FIFO_CONFIG;
   wire sel_scfg  = avs_address == sfr_pkg::OFF_SEQ_CONFIG;
   wire sel_res   = avs_address == sfr_pkg::OFF_RESULT_PORT;
   wire sel_cmd   = avs_address == sfr_pkg::OFF_COMMAND_PORT;
   wire sel_lock  = avs_address == sfr_pkg::OFF_SLEEP_LOCK;
   wire sel_trig  = avs_address == sfr_pkg::OFF_SLEEP_TRIG;
   wire sel_stat  = avs_address == sfr_pkg::OFF_IRQ_STATUS;
   wire sel_mask  = avs_address == sfr_pkg::OFF_IRQ_MASK;

   // Control decode
   wire [2:0] src      = fifo_config[sfr_pkg::SRC_LSB +: 3];
   wire       fifo_en  = fifo_config[sfr_pkg::FIFO_EN_BIT];
   wire       halt_bit = seq_config[sfr_pkg::HALT_BIT];
   wire       unlocked = sleep_lock == sfr_pkg::SLEEP_PASSWORD;
   wire       res_empty = res_count == '0;
   wire       res_full  = res_count == (RAW+1)'(RES_DEPTH);
   wire       cmd_full  = cmd_count == (CAW+1)'(CMD_DEPTH);
   assign cmd_empty = cmd_count == '0;

   ////////////////////////////////////////////////////////////////////////////
   // Result source selection
   logic        in_valid;
   logic        in_two;
   logic [31:0] in_word;
   logic [31:0] in_second;
   always_comb
   begin
      in_valid  = 1'b0;
      in_two    = 1'b0;
      in_word   = 32'h0000_0000;
      in_second = 32'h0000_0000;
      case (src)
         sfr_pkg::SRC_DFT:
         begin
            in_valid  = dft_valid;
            in_two    = 1'b1;
            in_word   = {{14{dft_data.re[17]}}, dft_data.re};
            in_second = {{14{dft_data.im[17]}}, dft_data.im};
         end
         sfr_pkg::SRC_SINC2:
         begin
            in_valid = sinc2_valid;
            in_word  = {16'h0000, sinc2_data};
         end
         sfr_pkg::SRC_VARIANCE:
         begin
            in_valid  = variance_valid;
            in_two    = 1'b1;
            in_word   = {16'h0000, variance_data[15:0]};
            in_second = {18'h00000, variance_data[29:16]};
         end
         sfr_pkg::SRC_MEAN:
         begin
            in_valid = mean_valid;
            in_word  = {16'h0000, mean_data};
         end
         default:
         begin
            in_valid = sinc3_valid;
            in_word  = {16'h0000, sinc3_data};
         end
      endcase
   end

   // Push and pop terms; second word of a pair goes out the cycle after
   wire [31:0] push_word = pend ? pend_word : in_word;
   wire        push_req  = pend | in_valid;
   wire        res_push  = fifo_en & push_req & ~res_full;
   wire        res_pop   = fifo_en & acc_rd & sel_res & rd_had;
   wire        res_lost  = fifo_en & ((pend & in_valid) | (push_req & res_full));
   wire        cmd_push  = acc_wr & sel_cmd & ~cmd_full;
   wire        cmd_drop  = acc_wr & sel_cmd & cmd_full;
   wire        cmd_take  = cmd_pop & ~cmd_empty;
   wire        underflow = cmd_pop & cmd_empty & halt_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake and read capture
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         done   <= 1'b0;
         rd_had <= 1'b0;
      end
      else
      begin
         done <= req & ~done;
         if (first_rd)
            rd_had <= sel_res & ~res_empty;
      end
   end

   // Read multiplexer
   logic [31:0] next_readdata;
   always_comb
   begin
      next_readdata = 32'h0000_0000;
      if (sel_fcfg)
         next_readdata = {16'h0000, fifo_config};
      else if (sel_scfg)
         next_readdata = {30'h0000_0000, seq_config};
      else if (avs_address == sfr_pkg::OFF_CHECKSUM)
         next_readdata = {24'h000000, checksum};
      else if (avs_address == sfr_pkg::OFF_TIMEOUT)
         next_readdata = {2'h0, timeout_q};
      else if (sel_res)
         next_readdata = res_empty ? 32'h0000_0000 : res_mem[res_rd];
      else if (sel_lock)
         next_readdata = {12'h000, sleep_lock};
      else if (sel_trig)
         next_readdata = {31'h0000_0000, sleep_trig};
      else if (sel_stat)
         next_readdata = {28'h0000000, irq_status};
      else if (sel_mask)
         next_readdata = {28'h0000000, irq_mask};
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         avs_readdata <= 32'h0000_0000;
      else if (first_rd)
         avs_readdata <= next_readdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software control registers
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         fifo_config <= sfr_pkg::FIFO_CONFIG_RESET;
         seq_config  <= sfr_pkg::SEQ_CONFIG_RESET;
         sleep_lock  <= 20'h00000;
         sleep_trig  <= 1'b0;
         irq_mask    <= 4'h0;
      end
      else if (acc_wr)
      begin
         if (sel_fcfg)
            fifo_config <= 16'(merge({16'h0000, fifo_config}, avs_writedata, avs_byteenable));
         if (sel_scfg)
            seq_config <= 2'(merge({30'h0000_0000, seq_config}, avs_writedata, avs_byteenable));
         if (sel_lock)
            sleep_lock <= 20'(merge({12'h000, sleep_lock}, avs_writedata, avs_byteenable));
         if (sel_trig && unlocked && avs_byteenable[0])
            sleep_trig <= avs_writedata[0];
         if (sel_mask)
            irq_mask <= 4'(merge({28'h0000000, irq_mask}, avs_writedata, avs_byteenable));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result FIFO storage
   always_ff @(posedge clock)
   begin
      if (res_push)
         res_mem[res_wr] <= push_word;
   end

   // Result FIFO pointers, held empty while disabled
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         res_wr    <= '0;
         res_rd    <= '0;
         res_count <= '0;
         pend      <= 1'b0;
         pend_word <= 32'h0000_0000;
      end
      else if (!fifo_en)
      begin
         res_wr    <= '0;
         res_rd    <= '0;
         res_count <= '0;
         pend      <= 1'b0;
      end
      else
      begin
         if (res_push)
            res_wr <= res_wr + 1'b1;
         if (res_pop)
            res_rd <= res_rd + 1'b1;
         res_count <= res_count + (RAW+1)'(res_push) - (RAW+1)'(res_pop);
         pend      <= ~pend & in_valid & in_two & res_push;
         if (~pend & in_valid & in_two)
            pend_word <= in_second;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command FIFO storage and sequencer read port
   always_ff @(posedge clock)
   begin
      if (cmd_push)
         cmd_mem[cmd_wr] <= avs_writedata;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         cmd_wr    <= '0;
         cmd_rd    <= '0;
         cmd_count <= '0;
         cmd_valid <= 1'b0;
         cmd_data  <= 32'h0000_0000;
      end
      else
      begin
         if (cmd_push)
            cmd_wr <= cmd_wr + 1'b1;
         if (cmd_take)
         begin
            cmd_rd   <= cmd_rd + 1'b1;
            cmd_data <= cmd_mem[cmd_rd];
         end
         cmd_valid <= cmd_take;
         cmd_count <= cmd_count + (CAW+1)'(cmd_push) - (CAW+1)'(cmd_take);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer status: checksum, timeout, halt, sleep
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         checksum    <= sfr_pkg::CHECKSUM_RESET;
         timeout_q   <= 30'h0000_0000;
         seq_halted  <= 1'b0;
         sleep_enter <= 1'b0;
      end
      else
      begin
         if (cmd_executed)
            checksum <= crc8_word(checksum, cmd_executed_word);
         timeout_q <= seq_timeout_count;
         if (underflow)
            seq_halted <= 1'b1;
         else if (cmd_push || !halt_bit)
            seq_halted <= 1'b0;
         sleep_enter <= seq_end & sleep_trig;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: set wins over write-one-to-clear
   sfr_pkg::sfr_irq_t events;
   assign events = '{slept: seq_end & sleep_trig, halted: underflow, res_drop: res_lost, cmd_drop: cmd_drop};
   wire [3:0] w1c = (acc_wr && sel_stat) ? (avs_writedata[3:0] & {4{avs_byteenable[0]}}) : 4'h0;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         irq_status <= 4'h0;
      else
         irq_status <= (irq_status & ~w1c) | events;
   end

   assign irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence s_rd_start;
      avs_read && !done;
   endsequence

   sequence s_rd_answer;
      !avs_waitrequest && avs_read;
   endsequence

   chk_bus_answer: assert property (s_rd_start |=> s_rd_answer)
      else $error("read not answered after one wait cycle");
   chk_empty_read_zero: assert property ((s_rd_start and (sel_res && res_empty)) |=> avs_readdata == 32'h0)
      else $error("empty result read did not return zero");
   chk_disable_empty: assert property (!fifo_en |=> res_count == '0 && res_rd == '0 && res_wr == '0)
      else $error("disabled result fifo not held empty");
   chk_full_write_drop: assert property ((acc_wr && sel_cmd && cmd_full) |=> cmd_wr == $past(cmd_wr))
      else $error("write to full command fifo was stored");
   chk_crc_hold: assert property (!cmd_executed |=> checksum == $past(checksum))
      else $error("checksum moved without an executed command");
   chk_lock_gate: assert property ((acc_wr && sel_trig && !unlocked) |=> $stable(sleep_trig))
      else $error("sleep trigger changed while locked");
   chk_relock_on_other: assert property ((acc_wr && sel_lock && avs_byteenable == 4'hF
      && avs_writedata[19:0] != sfr_pkg::SLEEP_PASSWORD) |=> !unlocked)
      else $error("lock not engaged after non-password write");
   chk_sleep_entry: assert property ((seq_end && sleep_trig) |=> sleep_enter ##1 !sleep_enter || seq_end)
      else $error("sleep not entered at sequence end");
   chk_pop_oldest: assert property ((acc_rd && sel_res && rd_had && fifo_en) |=> res_rd == $past(res_rd) + 1'b1)
      else $error("result read did not remove the oldest word");
   chk_underflow_halt: assert property ((cmd_pop && cmd_empty && halt_bit) |=> seq_halted [*1] ##0 irq_status[2])
      else $error("underflow did not halt the sequencer");
   chk_retry_no_halt: assert property ((!halt_bit && !seq_halted) |=> !seq_halted)
      else $error("sequencer halted with halt bit clear");

endmodule

`default_nettype wire

// ==== bench/sfr_seq_model.sv ====
// Behavioural sequencer core that faces the command side of the register bank.
// Assumes the bank's single clock and active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module sfr_seq_model (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // Bench control
   input  wire logic        run,
   input  wire logic        end_req,
   // Command side of the bank
   input  wire logic        cmd_valid,
   input  wire logic [31:0] cmd_data,
   output logic             cmd_pop,
   output logic             cmd_executed,
   output logic [31:0]      cmd_executed_word,
   output logic [29:0]      seq_timeout_count,
   output logic             seq_end
);
   ////////////////////////////////////////////////////////////////////////////
   // Pop while running, even on empty, and retire each word a cycle later
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         cmd_pop           <= 1'b0;
         cmd_executed      <= 1'b0;
         cmd_executed_word <= 32'h00000000;
         seq_timeout_count <= 30'h00000000;
         seq_end           <= 1'b0;
      end
      else
      begin
         cmd_pop           <= run;
         cmd_executed      <= cmd_valid;
         // Idle word toggles so a stale value never looks valid
         cmd_executed_word <= cmd_valid ? cmd_data : ~cmd_executed_word;
         seq_timeout_count <= seq_timeout_count + {29'h0, run};
         seq_end           <= end_req;
      end
   end
endmodule

`default_nettype wire

// ==== bench/sequencer_fifo_control_regs_bench.sv ====
// Self-checking bench for the sequencer and result FIFO register bank.
// Assumes the bank's Avalon-MM slave with waitrequest and a sequencer model.
`timescale 1ns/1ps
`default_nettype none

module sequencer_fifo_control_regs_bench;
   ////////////////////////////////////////////////////////////////////////////
   // Stimulus and observed signals
   logic              clock = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [15:0]       avs_address = 16'h0000;
   logic [31:0]       avs_writedata = 32'h00000000, avs_readdata, rdata, cmd_data, xw;
   logic              avs_waitrequest, cmd_pop, cmd_valid, cmd_empty, seq_halted, xv;
   logic              sleep_enter, irq, seq_end, run = 1'b0, end_req = 1'b0, vld = 1'b0;
   logic [29:0]       tcount;
   logic [7:0]        crc;
   logic [3:0]        be = 4'hF;
   logic [15:0]       s3 = 16'h8120;
   sfr_pkg::sfr_dft_t dft = '{re: 18'h20001, im: 18'h01234};
   logic [31:0]       got_q [$];
   int                fail_count = 0, n_compared = 0, slp_n = 0;
   logic [31:0]       exp0 [8] = '{32'h8120, 32'h8121, 32'hFFFE0001, 32'h4567, 32'h1234, 32'h89AB, 32'h8126, 32'h8127};
   logic [31:0]       exp1 [8] = '{32'h0, 32'h0, 32'h1234, 32'h0, 32'h2BCD, 32'h0, 32'h0, 32'h0};

   ////////////////////////////////////////////////////////////////////////////
   // Clock, bank and sequencer model
   always #10 clock = ~clock;

   sfr_regs #(.RES_DEPTH(4), .CMD_DEPTH(4)) dut_u (
      .clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sinc3_valid(vld), .sinc3_data(s3), .dft_valid(vld), .dft_data(dft),
      .sinc2_valid(vld), .sinc2_data(16'h4567), .variance_valid(vld), .variance_data(30'h2BCD1234),
      .mean_valid(vld), .mean_data(16'h89AB), .cmd_pop(cmd_pop), .cmd_valid(cmd_valid),
      .cmd_data(cmd_data), .cmd_empty(cmd_empty), .seq_halted(seq_halted), .cmd_executed(xv),
      .cmd_executed_word(xw), .seq_timeout_count(tcount), .seq_end(seq_end),
      .sleep_enter(sleep_enter), .irq(irq));

   sfr_seq_model model_u (
      .clock(clock), .resetn(resetn), .run(run), .end_req(end_req), .cmd_valid(cmd_valid),
      .cmd_data(cmd_data), .cmd_pop(cmd_pop), .cmd_executed(xv), .cmd_executed_word(xw),
      .seq_timeout_count(tcount), .seq_end(seq_end));

   // Collect delivered commands and sleep pulses
   always @(posedge clock)
   begin
      if (cmd_valid === 1'b1) got_q.push_back(cmd_data);
      if (sleep_enter === 1'b1) slp_n++;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus cycle, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      // Waitrequest is sampled at the rising edge; only the watchdog ends a hang
      do
         @(posedge clock);
      while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) fail_count++;
      if (g !== e) $display("wrong value at %0t: got %h expected %h", $time, g, e);
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdata, e);
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   // One valid pulse on every result source, then two idle cycles
   task automatic srcs();
      vld <= 1'b1;
      @(posedge clock);
      vld <= 1'b0;
      repeat (2) @(posedge clock);
   endtask

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [31:0] w);
      for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? sfr_pkg::CRC_POLY : 8'h00);
      return c;
   endfunction

   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial
   begin
      #200000;
      fail_count++;
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial
   begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rd(sfr_pkg::OFF_FIFO_CONFIG, 32'h1010);
      rd(sfr_pkg::OFF_SEQ_CONFIG, 32'h2);
      rd(sfr_pkg::OFF_CHECKSUM, 32'h1);
      rd(sfr_pkg::OFF_SLEEP_LOCK, 32'h0);
      rd(sfr_pkg::OFF_SLEEP_TRIG, 32'h0);
      rd(sfr_pkg::OFF_RESULT_PORT, 32'h0);
      rd(16'h2400, 32'h0);
      $display("test reset values done");
      wr(sfr_pkg::OFF_FIFO_CONFIG, 32'h7010);
      srcs();
      rd(sfr_pkg::OFF_RESULT_PORT, 32'h0);
      wr(sfr_pkg::OFF_FIFO_CONFIG, 32'h7810);
      srcs();
      wr(sfr_pkg::OFF_FIFO_CONFIG, 32'h7010);
      wr(sfr_pkg::OFF_FIFO_CONFIG, 32'h7810);
      rd(sfr_pkg::OFF_RESULT_PORT, 32'h0);
      for (int c = 0; c < 8; c++)
      begin
         wr(sfr_pkg::OFF_FIFO_CONFIG, 32'h1810 | (32'(c) << 13));
         s3 <= 16'h8120 + 16'(c);
         srcs();
         rd(sfr_pkg::OFF_RESULT_PORT, exp0[c]);
         if (c == 2 || c == 4) rd(sfr_pkg::OFF_RESULT_PORT, exp1[c]);
         rd(sfr_pkg::OFF_RESULT_PORT, 32'h0);
      end
      // Overfill the result FIFO: the fifth word is lost, the oldest survives
      for (int i = 0; i < 5; i++)
      begin
         s3 <= 16'hA000 + 16'(i);
         srcs();
      end
      rd(sfr_pkg::OFF_IRQ_STATUS, 32'h2);
      wr(sfr_pkg::OFF_IRQ_STATUS, 32'h2);
      rd(sfr_pkg::OFF_RESULT_PORT, 32'hA000);
      $display("test result sources done");
      for (int i = 0; i < 5; i++) wr(sfr_pkg::OFF_COMMAND_PORT, 32'hC0DE0000 + 32'(i));
      rd(sfr_pkg::OFF_IRQ_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(sfr_pkg::OFF_IRQ_MASK, 32'hF);
      chk({31'h0, irq}, 32'h1);
      wr(sfr_pkg::OFF_IRQ_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      run <= 1'b1;
      for (int n = 0; n < 30 && seq_halted !== 1'b1; n++) @(posedge clock);
      run <= 1'b0;
      repeat (3) @(posedge clock);
      chk(32'(got_q.size()), 32'h4);
      crc = sfr_pkg::CHECKSUM_RESET;
      for (int i = 0; i < 4; i++) chk(got_q[i], 32'hC0DE0000 + 32'(i));
      for (int i = 0; i < 4; i++) crc = crc8(crc, 32'hC0DE0000 + 32'(i));
      chk({31'h0, seq_halted}, 32'h1);
      chk({31'h0, cmd_empty}, 32'h1);
      rd(sfr_pkg::OFF_IRQ_STATUS, 32'h4);
      rd(sfr_pkg::OFF_CHECKSUM, {24'h0, crc});
      rd(sfr_pkg::OFF_TIMEOUT, {2'h0, tcount});
      wr(sfr_pkg::OFF_SEQ_CONFIG, 32'h0);
      wr(sfr_pkg::OFF_IRQ_STATUS, 32'h4);
      run <= 1'b1;
      repeat (6) @(posedge clock);
      run <= 1'b0;
      chk({31'h0, seq_halted}, 32'h0);
      rd(sfr_pkg::OFF_IRQ_STATUS, 32'h0);
      $display("test command path done");
      wr(sfr_pkg::OFF_SLEEP_TRIG, 32'h1);
      rd(sfr_pkg::OFF_SLEEP_TRIG, 32'h0);
      end_req <= 1'b1;
      @(posedge clock);
      end_req <= 1'b0;
      repeat (3) @(posedge clock);
      chk(32'(slp_n), 32'h0);
      wr(sfr_pkg::OFF_SLEEP_LOCK, 32'hA47E5);
      rd(sfr_pkg::OFF_SLEEP_LOCK, 32'hA47E5);
      wr(sfr_pkg::OFF_SLEEP_TRIG, 32'h1);
      rd(sfr_pkg::OFF_SLEEP_TRIG, 32'h1);
      end_req <= 1'b1;
      @(posedge clock);
      end_req <= 1'b0;
      repeat (3) @(posedge clock);
      chk(32'(slp_n), 32'h1);
      rd(sfr_pkg::OFF_IRQ_STATUS, 32'h8);
      wr(sfr_pkg::OFF_SLEEP_LOCK, 32'h12345);
      wr(sfr_pkg::OFF_SLEEP_TRIG, 32'h0);
      rd(sfr_pkg::OFF_SLEEP_TRIG, 32'h1);
      // Partial lanes merge into the lock, so the password is not complete
      be <= 4'h3;
      wr(sfr_pkg::OFF_SLEEP_LOCK, 32'hA47E5);
      be <= 4'hF;
      rd(sfr_pkg::OFF_SLEEP_LOCK, 32'h147E5);
      wr(sfr_pkg::OFF_SLEEP_TRIG, 32'h0);
      rd(sfr_pkg::OFF_SLEEP_TRIG, 32'h1);
      $display("test sleep lock done");
      final_report();
   end
endmodule

`default_nettype wire
